/* hw/serial_port_consts.vh */
// constants of the serial register port: address map, wrap points, field positions
// assumes inclusion by bare name from the port's design files
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// pointer layout: top bit is the direction, low seven bits the location
`define SP_DIR_BIT 7
`define SP_LOC_MSB 6
// clock register region ends here and wraps to its base
`define SP_CLK_LAST 7'h1f
`define SP_CLK_BASE 7'h00
// user ram region ends here and wraps to its base
`define SP_RAM_LAST 7'h7f
`define SP_RAM_BASE 7'h20
// alarm 0 and alarm 1 register windows
`define SP_AL0_FIRST 7'h07
`define SP_AL0_LAST 7'h0a
`define SP_AL1_FIRST 7'h0b
`define SP_AL1_LAST 7'h0e
// control register write address and its write lock bit
`define SP_CTRL_WR_ADDR 8'h8f
`define SP_LOCK_BIT 6
// last bit index of a byte
`define SP_LAST_BIT 3'h7
`define SP_BIT_ONE 3'h1
`define SP_LOC_ONE 7'h01

`endif

/* hw/pin_filter.v */
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to sys_clk_i; output is a registered level
module pin_filter #(
  parameter RESET_LEVEL = 1'b0
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire pin_i,
  output reg level_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // the first stage feeds only the second; a change counts once stages two and three agree
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level_o <= RESET_LEVEL;
    end else if (clk_en_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end

endmodule // pin_filter

/* hw/serial_register_port.v */
// serial slave port of a real-time clock: spi or three-wire access to clock registers and ram
// assumes a register/ram store outside that answers reg_rd_o on the next clock via reg_rdata_i
//
// Contract
// - strap level picks four-wire spi (high) or three-wire (low) operation
// - device is slave only; master makes every shift clock edge
// - chip select high starts a transfer, low ends it
// - shift clock level at chip select rise fixes clock polarity
// - input captured on strobe edge, output changed on opposite shift edge
// - one clock per bit, address and data in whole eight-bit groups
// - output stays released until a whole read byte is ready
// - spi bytes move most significant bit first
// - first byte is address; direction bit 0 reads, 1 writes
// - address advances after every data byte while selected
// - clock region reads wrap 1fh to 00h
// - clock region writes wrap 9fh to 80h
// - ram reads wrap 7fh to 20h
// - ram writes wrap ffh to a0h
// - writes ignored while running from backup battery
// - write lock blocks all writes except one clearing the lock
// - three-wire: shared line, lsb first, sample rising, change falling
// - pointer on alarm 0 or 1 registers clears that alarm flag
`include "serial_port_consts.vh"

module serial_register_port (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire interface_select_i,
  input wire chip_select_in_i,
  input wire shift_clock_i,
  input wire serial_in_i,
  output reg serial_out_o,
  output reg serial_out_oe_o,
  input wire on_battery_i,
  input wire write_lock_i,
  output reg [7:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  output reg reg_wr_o,
  output reg reg_rd_o,
  input wire [7:0] reg_rdata_i,
  output reg alarm0_clear_o,
  output reg alarm1_clear_o
);

  wire cs_f;
  wire sclk_f;
  wire sdi_f;
  wire mode_f;
  reg cs_prev_q;
  reg sclk_prev_q;
  reg spi_mode_q;
  reg cpol_q;
  reg addr_phase_q;
  reg [2:0] bit_cnt_q;
  reg [7:0] rx_q;
  reg [7:0] ptr_q;
  reg [7:0] tx_q;
  reg tx_valid_q;
  reg load_q;

  // every pin from the master is filtered; idle levels chosen so reset sees no edge
  // all pins share the same four-clock delay, so data keeps its place against the clock
  // the cost: a shift clock half period must be at least three system clocks
  pin_filter #(.RESET_LEVEL(1'b0)) u_cs (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .pin_i(chip_select_in_i), .level_o(cs_f));
  pin_filter #(.RESET_LEVEL(1'b0)) u_sclk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .pin_i(shift_clock_i), .level_o(sclk_f));
  pin_filter #(.RESET_LEVEL(1'b0)) u_sdi (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .pin_i(serial_in_i), .level_o(sdi_f));
  pin_filter #(.RESET_LEVEL(1'b1)) u_mode (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .pin_i(interface_select_i), .level_o(mode_f));

  // edge classification on the filtered levels
  // the shift clock is an input only: this port never makes an edge of its own
  wire cs_rise = cs_f & ~cs_prev_q;
  wire sclk_rise = sclk_f & ~sclk_prev_q;
  wire sclk_fall = ~sclk_f & sclk_prev_q;
  // spi strobes on the edge back to idle; three-wire strobes on rising
  wire strobe = spi_mode_q ? (cpol_q ? sclk_rise : sclk_fall) : sclk_rise;
  wire shift = spi_mode_q ? (cpol_q ? sclk_fall : sclk_rise) : sclk_fall;
  // assembled byte including the bit taken this strobe
  wire [7:0] rx_new = spi_mode_q ? {rx_q[6:0], sdi_f} : {sdi_f, rx_q[7:1]};
  wire byte_done = strobe & (bit_cnt_q == `SP_LAST_BIT);

  // pointer advance with per-region wrap; direction bit is kept, so reads and writes
  // each wrap inside their own half of the map
  function [7:0] next_ptr;
    input [7:0] p;
    begin
      if (p[`SP_LOC_MSB:0] == `SP_CLK_LAST) begin
        next_ptr = {p[`SP_DIR_BIT], `SP_CLK_BASE};
      end else if (p[`SP_LOC_MSB:0] == `SP_RAM_LAST) begin
        next_ptr = {p[`SP_DIR_BIT], `SP_RAM_BASE};
      end else begin
        next_ptr = {p[`SP_DIR_BIT], p[`SP_LOC_MSB:0] + `SP_LOC_ONE};
      end
    end
  endfunction

  // blocked writes still advance the pointer, so a burst keeps its alignment
  // battery blocks every write; the lock lets through only a control write clearing it
  wire wr_allowed = ~on_battery_i & (~write_lock_i |
    ((ptr_q == `SP_CTRL_WR_ADDR) & ~rx_new[`SP_LOCK_BIT]));

  // alarm window decode for the location an access is issued to
  // windows compare the location only, so read and write forms both match
  function in_win;
    input [6:0] loc;
    input [6:0] first;
    input [6:0] last;
    begin
      in_win = (loc >= first) && (loc <= last);
    end
  endfunction

  // pointer after one advance, and the location parts that the alarm decode compares
  wire [7:0] ptr_next = next_ptr(ptr_q);
  wire [`SP_LOC_MSB:0] rx_loc = rx_new[`SP_LOC_MSB:0];
  wire [`SP_LOC_MSB:0] ptr_loc = ptr_q[`SP_LOC_MSB:0];
  wire [`SP_LOC_MSB:0] next_loc = ptr_next[`SP_LOC_MSB:0];

  // transfer sequencer: address phase, data bytes, read fetch and write issue
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cs_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      spi_mode_q <= 1'b1;
      cpol_q <= 1'b0;
      addr_phase_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      tx_valid_q <= 1'b0;
      load_q <= 1'b0;
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
      reg_addr_o <= 8'h00;
      reg_wdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      alarm0_clear_o <= 1'b0;
      alarm1_clear_o <= 1'b0;
    end else if (clk_en_i) begin
      cs_prev_q <= cs_f;
      sclk_prev_q <= sclk_f;
      // strobes last one clock; address and data outputs hold until the next access
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      alarm0_clear_o <= 1'b0;
      alarm1_clear_o <= 1'b0;
      load_q <= reg_rd_o;
      if (cs_rise) begin
        // strap and idle clock level are caught at selection, not at reset
        spi_mode_q <= mode_f;
        cpol_q <= sclk_f;
        addr_phase_q <= 1'b1;
        bit_cnt_q <= 3'h0;
        tx_valid_q <= 1'b0;
        serial_out_oe_o <= 1'b0;
      end else if (!cs_f) begin
        // deselected: partial byte dropped, output released, a late fetch is discarded
        // a fetch still in flight is not loaded here, so the next frame starts clean
        addr_phase_q <= 1'b1;
        bit_cnt_q <= 3'h0;
        tx_valid_q <= 1'b0;
        serial_out_oe_o <= 1'b0;
      end else begin
        // one bit per strobe edge; the counter wraps to zero at every byte boundary
        if (strobe) begin
          rx_q <= rx_new;
          bit_cnt_q <= bit_cnt_q + `SP_BIT_ONE;
        end
        if (byte_done && addr_phase_q) begin
          ptr_q <= rx_new;
          addr_phase_q <= 1'b0;
          if (!rx_new[`SP_DIR_BIT]) begin
            reg_rd_o <= 1'b1;
            reg_addr_o <= rx_new;
            alarm0_clear_o <= in_win(rx_loc, `SP_AL0_FIRST, `SP_AL0_LAST);
            alarm1_clear_o <= in_win(rx_loc, `SP_AL1_FIRST, `SP_AL1_LAST);
          end
        end else if (byte_done && ptr_q[`SP_DIR_BIT]) begin
          // write byte complete: issue if permitted, then advance
          reg_wr_o <= wr_allowed;
          reg_addr_o <= ptr_q;
          reg_wdata_o <= rx_new;
          alarm0_clear_o <= in_win(ptr_loc, `SP_AL0_FIRST, `SP_AL0_LAST);
          alarm1_clear_o <= in_win(ptr_loc, `SP_AL1_FIRST, `SP_AL1_LAST);
          ptr_q <= ptr_next;
        end else if (byte_done) begin
          // read byte sent: advance and prefetch the next location for a burst
          reg_rd_o <= 1'b1;
          reg_addr_o <= ptr_next;
          alarm0_clear_o <= in_win(next_loc, `SP_AL0_FIRST, `SP_AL0_LAST);
          alarm1_clear_o <= in_win(next_loc, `SP_AL1_FIRST, `SP_AL1_LAST);
          ptr_q <= ptr_next;
        end
        // the fetch lands three clocks after a byte ends; a shorter shift clock half
        // period than three clocks would shift out a stale byte
        if (load_q) begin
          // whole byte now held; drive starts at the next shift edge
          tx_q <= reg_rdata_i;
          tx_valid_q <= 1'b1;
        end else if (shift && tx_valid_q) begin
          serial_out_o <= spi_mode_q ? tx_q[7] : tx_q[0];
          tx_q <= spi_mode_q ? {tx_q[6:0], 1'b0} : {1'b0, tx_q[7:1]};
          serial_out_oe_o <= 1'b1;
        end
      end
    end
  end

endmodule // serial_register_port

/* sim/serial_register_port_checker.sv */
// checker of the serial port: write gating, direction, alarm windows, output release
// assumes clk_en_i high while the port is in use
module serial_register_port_checker (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire interface_select_i,
  input wire chip_select_in_i,
  input wire shift_clock_i,
  input wire serial_in_i,
  input wire serial_out_o,
  input wire serial_out_oe_o,
  input wire on_battery_i,
  input wire write_lock_i,
  input wire reg_wr_o,
  input wire reg_rd_o,
  input wire alarm0_clear_o,
  input wire alarm1_clear_o,
  input wire [7:0] reg_addr_o,
  input wire [7:0] reg_wdata_o,
  input wire [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_wr_dir; reg_wr_o |-> reg_addr_o[7]; endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("write at read address");
  property p_rd_dir; reg_rd_o |-> !reg_addr_o[7]; endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("read at write address");
  property p_bat; reg_wr_o |-> !on_battery_i; endproperty
  a_bat: assert property (p_bat) else $error("write on battery");
  property p_lock; reg_wr_o && write_lock_i |-> reg_addr_o == 8'h8f && !reg_wdata_o[6];
  endproperty
  a_lock: assert property (p_lock) else $error("write through lock");
  property p_al0; alarm0_clear_o |-> reg_addr_o[6:0] inside {[7'h07:7'h0a]}; endproperty
  a_al0: assert property (p_al0) else $error("alarm 0 clear off window");
  property p_al1; alarm1_clear_o |-> reg_addr_o[6:0] inside {[7'h0b:7'h0e]}; endproperty
  a_al1: assert property (p_al1) else $error("alarm 1 clear off window");
  // the pin filter costs four clocks and the release one more, so eight clears the margin
  property p_release; !chip_select_in_i [*8] |-> !serial_out_oe_o; endproperty
  a_release: assert property (p_release) else $error("output held after deselect");
  property p_oe_rd; $rose(serial_out_oe_o) |-> !reg_addr_o[7] && chip_select_in_i; endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("output driven outside read");
endmodule // serial_register_port_checker

bind serial_register_port serial_register_port_checker i_serial_register_port_checker (.*);

/* sim/link_master.sv */
// link master model: chip select, shift clock and data, four clocks per shift clock half period
// assumes the caller opens a frame before shifting and closes it afterwards
module link_master (
  input wire sys_clk_i,
  input wire miso_i,
  output logic cs_o = 1'b0,
  output logic sclk_o = 1'b0,
  output logic sdo_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pol = 1'b0;
  task tick;
    repeat (8) @(posedge sys_clk_i);
  endtask
  // half of a 200 ns shift clock period
  task half;
    repeat (4) @(posedge sys_clk_i);
  endtask
  // clock stands at its idle level before select rises
  task open(input logic p);
    pol = p;
    sclk_o <= p;
    tick;
    cs_o <= 1'b1;
    tick;
  endtask
  // one bit per 200 ns: data changes with the port's shift edge, a half period before
  // its strobe edge; the read bit is taken just before the next shift edge, since the
  // port's filtered output lags each shift edge by five clocks
  // three-wire frames assume an idle-low clock
  task shift(input logic spi, input logic [7:0] tx, input int nb, output logic [7:0] rx);
    int b;
    for (int i = 0; i < nb; i++) begin
      b = spi ? 7 - i : i;
      sdo_o <= tx[b];
      if (!spi) half;
      sclk_o <= ~pol;
      half;
      if (spi) begin
        sclk_o <= pol;
        half;
      end
      rx[b] = miso_i;
      if (!spi) sclk_o <= pol;
    end
  endtask
  // released data line shows the inverse of its last value
  task close;
    tick;
    cs_o <= 1'b0;
    sdo_o <= ~sdo_o;
    tick;
    tick;
  endtask
endmodule // link_master

/* sim/serial_register_port_tb.sv */
// bench of serial_register_port: link master model plus a register store
// assumes link_master and the checker bind are compiled first
module serial_register_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, reset_n_i = 0, sel = 1, bat = 0, lock = 0;
  logic [7:0] rdata = 8'h00;
  logic [15:0] wq[$];
  int num_errors = 0, tests_run = 0, cyc = 0, n_al0 = 0, n_al1 = 0;
  wire cs, sclk, mdo, sout, oe, wr, rd, al0, al1;
  wire [7:0] addr, wdata;
  wire serial_in = (!sel && oe) ? sout : mdo; // shared line in three-wire mode
  wire miso = oe ? sout : ~sout; // undriven output reads as junk
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  link_master i_link_master (.sys_clk_i, .miso_i(miso), .cs_o(cs), .sclk_o(sclk), .sdo_o(mdo));
  serial_register_port i_serial_register_port (.sys_clk_i, .reset_n_i, .clk_en_i(1'b1),
    .interface_select_i(sel), .chip_select_in_i(cs), .shift_clock_i(sclk), .serial_in_i(serial_in),
    .serial_out_o(sout), .serial_out_oe_o(oe), .on_battery_i(bat), .write_lock_i(lock),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_rdata_i(rdata), .alarm0_clear_o(al0), .alarm1_clear_o(al1));
  function automatic logic [7:0] sv(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ 8'h96;
  endfunction
  function automatic int win(input logic [7:0] a, input logic [6:0] lo, hi);
    return int'(a[6:0] >= lo && a[6:0] <= hi);
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] a);
    return {a[7], a[6:0] == 7'h1f ? 7'h00 : a[6:0] == 7'h7f ? 7'h20 : a[6:0] + 7'h01};
  endfunction
  // store answers a read strobe next clock, logs writes, and bounds the run
  always @(posedge sys_clk_i) begin
    rdata <= rd ? sv(addr) : ~rdata;
    if (wr) wq.push_back({addr, wdata});
    if (al0 === 1'b1) n_al0 <= n_al0 + 1;
    if (al1 === 1'b1) n_al1 <= n_al1 + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      close_out;
    end
  end
  task chk(input logic [15:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one frame of address and n bytes; ok says whether writes should land
  task run(input logic spi, pol, input logic [7:0] a, input int n, input logic ok);
    logic [7:0] r, e;
    int a0, a1, x0, x1;
    wq.delete();
    a0 = n_al0;
    a1 = n_al1;
    x0 = 0;
    x1 = 0;
    e = a;
    i_link_master.open(pol);
    i_link_master.shift(spi, a, 8, r);
    for (int k = 0; k < n; k++) begin
      i_link_master.shift(spi, 8'h35 + k[7:0], 8, r);
      if (!a[7]) chk(r, sv(e), "read data");
      e = nxt(e);
    end
    i_link_master.close();
    chk(wq.size(), (a[7] && ok) ? n : 0, "write count");
    e = a;
    for (int k = 0; k < wq.size(); k++) begin
      chk(wq[k], {e, 8'h35 + k[7:0]}, "write");
      e = nxt(e);
    end
    // every location accessed; a read also prefetches the one after its last byte
    e = a;
    for (int k = 0; k <= n; k++) begin
      if (k < n || !a[7]) begin
        x0 += win(e, 7'h07, 7'h0a);
        x1 += win(e, 7'h0b, 7'h0e);
      end
      e = nxt(e);
    end
    chk(n_al0 - a0, x0, "alarm 0 clears");
    chk(n_al1 - a1, x1, "alarm 1 clears");
  endtask
  task t_wraps;
    run(1, 0, 8'h9f, 2, 1);
    run(1, 1, 8'hff, 2, 1);
    run(1, 0, 8'h1f, 2, 0);
    run(1, 1, 8'h7f, 2, 0);
  endtask
  task t_guards;
    bat <= 1'b1;
    run(1, 0, 8'h81, 1, 0);
    bat <= 1'b0;
    lock <= 1'b1;
    run(1, 0, 8'h8f, 1, 1);
    run(1, 0, 8'h8c, 1, 0);
    lock <= 1'b0;
  endtask
  task t_three;
    sel <= 1'b0;
    run(0, 0, 8'h8a, 1, 1);
    run(0, 0, 8'h22, 2, 0);
    sel <= 1'b1;
  endtask
  task t_abort;
    logic [7:0] r;
    wq.delete();
    i_link_master.open(0);
    i_link_master.shift(1, 8'h90, 8, r);
    i_link_master.shift(1, 8'h5a, 5, r);
    i_link_master.close();
    chk(wq.size(), 0, "aborted write");
    run(1, 0, 8'h91, 1, 1);
  endtask
  task close_out;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    t_wraps;
    t_guards;
    t_three;
    t_abort;
    close_out;
  end
endmodule // serial_register_port_tb
